// ---- logic/kbd_map.vh ----
// register indices, field positions and reset values of the keypad block
`ifndef KBD_MAP_VH
`define KBD_MAP_VH

// register indices; the byte address of each register is four times its index
`define KBD_IDX_CONTROL      8'h8C
`define KBD_IDX_LEVEL_SELECT 8'h8D
`define KBD_IDX_ENABLES      8'h8E
`define KBD_IDX_FLAGS        8'h8F

// width of the Avalon word address
`define KBD_ADDR_W           8

// number of keypad inputs
`define KBD_INPUTS           8

// control register fields
`define KBD_CTRL_GLOBAL_EN   0

// reset values
`define KBD_RST_CONTROL      8'h00
`define KBD_RST_LEVEL_SELECT 8'h00
`define KBD_RST_ENABLES      8'h00
`define KBD_RST_FLAGS        8'h00
`define KBD_RST_READDATA     32'h00000000
`define KBD_RST_SYNC         8'hFF

// clock cycles after reset during which pin levels are not trusted
`define KBD_PRIME_CYCLES     2'h2

`endif

// ---- logic/kbd_sync.v ----
// two-stage synchroniser for the eight keypad pins, with a warm-up gate
`timescale 1ns/1ns
`default_nettype none
`include "kbd_map.vh"

module kbd_sync (
	input  wire       clk,
	input  wire       reset_n,
	input  wire [7:0] pins,
	output wire [7:0] pins_sync,
	output reg        sync_valid
);

	localparam [7:0] sync_rst = `KBD_RST_SYNC;

	reg [7:0] stage1;
	reg [7:0] stage2;
	reg [1:0] prime_count;

	////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < `KBD_INPUTS; i = i + 1) begin : g_bit
			// stage1 is read by stage2 only
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					stage1[i] <= sync_rst[i];
					stage2[i] <= sync_rst[i];
				end else begin
					stage1[i] <= pins[i];
					stage2[i] <= stage1[i];
				end
			end
		end
	endgenerate

	assign pins_sync = stage2;

	////////////////////////////////////////////////////////////////////////
	// the reset value of the stages is not a real pin level, so hold off
	// detection until real samples have reached stage2
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prime_count <= 2'h0;
			sync_valid  <= 1'b0;
		end else if (prime_count != `KBD_PRIME_CYCLES) begin
			prime_count <= prime_count + 2'h1;
			sync_valid  <= 1'b0;
		end else begin
			sync_valid  <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ---- logic/kbd_avs.v ----
// Avalon-MM slave handshake: one wait cycle, then a one-cycle access strobe
`timescale 1ns/1ns
`default_nettype none

module kbd_avs (
	input  wire clk,
	input  wire reset_n,
	input  wire read,
	input  wire write,
	output reg  waitrequest,
	output wire take_read,
	output wire take_write,
	output wire rd_capture
);

	// waitrequest stands high until a request has been seen for one cycle,
	// drops for exactly one cycle, then rises again
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// read data are loaded in the first request cycle so they stand stable
	// for the whole cycle in which waitrequest is low
	assign rd_capture = read && waitrequest;
	assign take_read  = read && !waitrequest;
	assign take_write = write && !waitrequest;

endmodule
`default_nettype wire

// ---- logic/kbd_top.v ----
// keypad level-detect block: eight pins, event flags, shared request, wake
`timescale 1ns/1ns
`default_nettype none
`include "kbd_map.vh"

module kbd_top (
	input  wire        SYS_CLK,
	input  wire        RESET_N,
	input  wire [7:0]  KEY_INPUT_PIN,
	input  wire [7:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output wire        AVS_WAITREQUEST,
	output reg  [31:0] AVS_READDATA,
	output reg         KEY_IRQ,
	output reg         KEY_WAKE_REQ,
	output reg  [7:0]  KEY_PIN_IS_KEYPAD
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	reg  [7:0]  control;
	reg  [7:0]  key_level_select_reg;
	reg  [7:0]  key_interrupt_enables;
	reg  [7:0]  key_event_flags;

	reg  [7:0]  next_key_event_flags;
	reg  [31:0] next_readdata;
	wire [7:0]  level_hit;

	wire [7:0]  pins_sync;
	wire        sync_valid;
	wire        take_write;
	wire        rd_capture;
	wire        lane0_write;
	wire        global_enable;
	wire [7:0]  masked_flags;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser

	kbd_sync u_sync (
		.clk        (SYS_CLK),
		.reset_n    (RESET_N),
		.pins       (KEY_INPUT_PIN),
		.pins_sync  (pins_sync),
		.sync_valid (sync_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// bus handshake

	kbd_avs u_avs (
		.clk         (SYS_CLK),
		.reset_n     (RESET_N),
		.read        (AVS_READ),
		.write       (AVS_WRITE),
		.waitrequest (AVS_WAITREQUEST),
		.take_read   (),
		.take_write  (take_write),
		.rd_capture  (rd_capture)
	);

	// every register is eight bits wide and lives in byte lane 0; writes
	// that do not enable lane 0 change nothing
	assign lane0_write = take_write && AVS_BYTEENABLE[0];

	////////////////////////////////////////////////////////////////////////
	// software-written registers

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			control <= `KBD_RST_CONTROL;
		end else if (lane0_write && AVS_ADDRESS == `KBD_IDX_CONTROL) begin
			control <= {7'h00, AVS_WRITEDATA[`KBD_CTRL_GLOBAL_EN]};
		end
	end

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			key_level_select_reg <= `KBD_RST_LEVEL_SELECT;
		end else if (lane0_write && AVS_ADDRESS == `KBD_IDX_LEVEL_SELECT) begin
			key_level_select_reg <= AVS_WRITEDATA[7:0];
		end
	end

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			key_interrupt_enables <= `KBD_RST_ENABLES;
		end else if (lane0_write && AVS_ADDRESS == `KBD_IDX_ENABLES) begin
			key_interrupt_enables <= AVS_WRITEDATA[7:0];
		end
	end

	assign global_enable = control[`KBD_CTRL_GLOBAL_EN];

	////////////////////////////////////////////////////////////////////////
	// level detection, one comparator per input

	genvar i;
	generate
		for (i = 0; i < `KBD_INPUTS; i = i + 1) begin : g_level
			// select 0 matches a low pin, select 1 a high pin
			assign level_hit[i] = sync_valid &&
				(pins_sync[i] == key_level_select_reg[i]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// event flags

	// flags set whatever the enables hold; enables mask only the request and the wake.
	// a level present in the clearing cycle sets its flag again, so a key
	// still held reasserts at once
	always @* begin
		next_key_event_flags = key_event_flags;
		if (lane0_write && AVS_ADDRESS == `KBD_IDX_FLAGS) begin
			next_key_event_flags = 8'h00;
		end
		next_key_event_flags = next_key_event_flags | level_hit;
	end

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			key_event_flags <= `KBD_RST_FLAGS;
		end else begin
			key_event_flags <= next_key_event_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared request, wake request and pin function

	assign masked_flags = key_event_flags & key_interrupt_enables;

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			KEY_IRQ <= 1'b0;
		end else begin
			KEY_IRQ <= global_enable && (|masked_flags);
		end
	end

	// wake follows the live level so it does not wait for the flag stage;
	// it is not gated by the global enable so a masked core still wakes
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			KEY_WAKE_REQ <= 1'b0;
		end else begin
			KEY_WAKE_REQ <= |(level_hit & key_interrupt_enables);
		end
	end

	// low bit: the pad belongs to general-purpose I/O
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			KEY_PIN_IS_KEYPAD <= `KBD_RST_ENABLES;
		end else begin
			KEY_PIN_IS_KEYPAD <= key_interrupt_enables;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data

	always @* begin
		case (AVS_ADDRESS)
			`KBD_IDX_CONTROL: begin
				next_readdata = {24'h000000, control};
			end
			`KBD_IDX_LEVEL_SELECT: begin
				next_readdata = {24'h000000, key_level_select_reg};
			end
			`KBD_IDX_ENABLES: begin
				next_readdata = {24'h000000, key_interrupt_enables};
			end
			`KBD_IDX_FLAGS: begin
				next_readdata = {24'h000000, key_event_flags};
			end
			default: begin
				next_readdata = 32'h00000000;
			end
		endcase
	end

	// loaded in the first request cycle; held through the accepting edge
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			AVS_READDATA <= `KBD_RST_READDATA;
		end else if (rd_capture) begin
			AVS_READDATA <= next_readdata;
		end
	end

endmodule
`default_nettype wire

// ---- bench/kbd_keys.sv ----
// key matrix stand-in driving the eight keypad pins
`timescale 1ns/1ns
`default_nettype none
module kbd_keys (
	input  wire logic [7:0] idle,
	input  wire logic [7:0] press,
	output wire logic [7:0] pins
);
	// a held key pulls its pin to the opposite of its resting level
	assign pins = idle ^ press;
endmodule
`default_nettype wire

// ---- bench/kbd_top_asserts.sv ----
// checker on the keypad block's bus handshake and request outputs
`timescale 1ns/1ns
`default_nettype none
module kbd_top_asserts (
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	input wire logic [7:0]  KEY_INPUT_PIN,
	input wire logic [7:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic        AVS_WAITREQUEST,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        KEY_IRQ,
	input wire logic        KEY_WAKE_REQ,
	input wire logic [7:0]  KEY_PIN_IS_KEYPAD
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	wait_answer_a: assert property
		((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no answer");
	wait_once_a: assert property
		(!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low too long");
	wait_idle_a: assert property
		(!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST) else $error("answer without request");
	read_upper_a: assert property
		(AVS_READDATA[31:8] == 24'h000000) else $error("upper read bits set");
	unmapped_zero_a: assert property
		(AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[7:2] != 6'h23 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	read_stands_a: assert property
		(!AVS_READ |=> $stable(AVS_READDATA)) else $error("read data moved");
	irq_enable_a: assert property
		($rose(KEY_IRQ) |-> KEY_PIN_IS_KEYPAD != 8'h00) else $error("request with no enable");
	wake_enabled_a: assert property
		(KEY_WAKE_REQ |-> KEY_PIN_IS_KEYPAD != 8'h00) else $error("wake with no enable");
	pads_write_a: assert property
		($changed(KEY_PIN_IS_KEYPAD) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("pad mode moved without write");
endmodule
bind kbd_top kbd_top_asserts u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
	.KEY_INPUT_PIN(KEY_INPUT_PIN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA), .KEY_IRQ(KEY_IRQ),
	.KEY_WAKE_REQ(KEY_WAKE_REQ), .KEY_PIN_IS_KEYPAD(KEY_PIN_IS_KEYPAD));
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the keypad block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        SYS_CLK;
	logic        RESET_N;
	logic [7:0]  AVS_ADDRESS;
	logic        AVS_READ;
	logic        AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [3:0]  AVS_BYTEENABLE;
	wire         AVS_WAITREQUEST;
	wire  [31:0] AVS_READDATA;
	wire         KEY_IRQ;
	wire         KEY_WAKE_REQ;
	wire  [7:0]  KEY_PIN_IS_KEYPAD;
	wire  [7:0]  KEY_INPUT_PIN;
	logic [7:0]  idle, press, lvl, en;
	logic [7:0]  expq [$];
	logic [7:0]  regs [5] = '{8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h10};
	int          failures, checks_done, cyc, n;
	kbd_keys keys (.idle(idle), .press(press), .pins(KEY_INPUT_PIN));
	kbd_top DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .KEY_INPUT_PIN(KEY_INPUT_PIN),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA), .KEY_IRQ(KEY_IRQ),
		.KEY_WAKE_REQ(KEY_WAKE_REQ), .KEY_PIN_IS_KEYPAD(KEY_PIN_IS_KEYPAD));
	initial begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// reads note their expected byte; the watcher below compares it when the answer lands
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h000000, d};
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		if (!wr)
			expq.push_back(d);
		do
			@(posedge SYS_CLK);
		while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask
	task automatic hold_look(input logic [7:0] p);
		@(posedge SYS_CLK);
		press <= p;
		repeat (6) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
	endtask
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (AVS_READ && AVS_WAITREQUEST === 1'b0 && expq.size() > 0)
			check("readdata", AVS_READDATA[7:0], expq.pop_front());
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		RESET_N = 1'b0;
		AVS_ADDRESS = 8'h00;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h00000000;
		AVS_BYTEENABLE = 4'h1;
		press = 8'h00;
		idle = 8'hFF;
		failures = 0;
		checks_done = 0;
		cyc = 0;
		void'($urandom(21423));
		repeat (2) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		foreach (regs[i])
			bus(1'b0, regs[i], 8'h00);
		lvl = 8'($urandom);
		// bit 7 stays masked so at least one set flag is never allowed to request
		en = 8'(($urandom | 32'h00000001) & 32'h0000007F);
		idle <= ~lvl;
		bus(1'b1, 8'h8D, lvl);
		bus(1'b1, 8'h8E, en);
		bus(1'b1, 8'h8C, 8'h01);
		bus(1'b0, 8'h8E, en);
		bus(1'b1, 8'h8F, 8'h00);
		bus(1'b0, 8'h8F, 8'h00);
		check("pads", KEY_PIN_IS_KEYPAD, en);
		for (n = 0; n < 8; n++) begin
			// the pin reaches the wake flop on the third edge after it moves
			@(posedge SYS_CLK);
			press <= 8'h01 << n;
			repeat (2) @(posedge SYS_CLK);
			@(negedge SYS_CLK);
			check("wake early", {7'h00, KEY_WAKE_REQ}, 8'h00);
			@(posedge SYS_CLK);
			@(negedge SYS_CLK);
			check("wake", {7'h00, KEY_WAKE_REQ}, {7'h00, en[n]});
			hold_look(8'h00);
			check("irq", {7'h00, KEY_IRQ}, {7'h00, en[n]});
			bus(1'b0, 8'h8F, 8'h01 << n);
			bus(1'b1, 8'h8F, 8'($urandom));
			bus(1'b0, 8'h8F, 8'h00);
			check("irq", {7'h00, KEY_IRQ}, 8'h00);
		end
		bus(1'b1, 8'h8C, 8'h00);
		hold_look(8'h01);
		check("irq", {7'h00, KEY_IRQ}, 8'h00);
		check("wake", {7'h00, KEY_WAKE_REQ}, 8'h01);
		hold_look(8'h00);
		bus(1'b1, 8'h8C, 8'h01);
		bus(1'b0, 8'h8F, 8'h01);
		@(negedge SYS_CLK);
		check("irq", {7'h00, KEY_IRQ}, 8'h01);
		final_report();
	end
endmodule
`default_nettype wire
